//--- verilog/csrc_pkg.sv
// Notes on behaviour
// RQ1 - PLL mode 01 powers the PLL down
// RQ2 - PLL mode 00 runs the PLL normally
// RQ3 - Bypass bit chooses direct feed or divider
// RQ4 - Source select 0 takes external clock input
// RQ5 - Source select 1 takes internal oscillator
// RQ6 - Polarity bit: 0 positive, 1 negative
// RQ7 - Reset: PLL off, code 000, divider, external
// RQ8 - Oscillator divider ratios one through six
// RQ9 - External source keeps internal oscillator off
// RQ10 - External oscillator feeds feedback prescaler directly; code routes it there only in PLL mode 00
// RQ11 - Software keeps divider in above channel limit
// RQ12 - Software sets normal mode for external lock
package csrc_pkg;
  // Register addresses on the serial control port
  localparam logic [12:0] CSRC_PLL_CONTROL_ADDR = 13'h0010;
  localparam logic [12:0] CSRC_OSC_DIV_RATIO_ADDR = 13'h01E0;
  localparam logic [12:0] CSRC_DIST_ROUTING_ADDR = 13'h01E1;
  localparam logic [12:0] CSRC_UPDATE_ADDR = 13'h0232;
  // Field positions
  localparam int CSRC_PLL_MODE_LSB = 0;
  localparam int CSRC_PD_POLARITY_BIT = 7;
  localparam int CSRC_DIV_CODE_LSB = 0;
  localparam int CSRC_BYPASS_BIT = 0;
  localparam int CSRC_SOURCE_BIT = 1;
  localparam int CSRC_UPDATE_BIT = 0;
  // PLL mode codes
  localparam logic [1:0] CSRC_PLL_NORMAL = 2'h0;
  localparam logic [1:0] CSRC_PLL_ASYNC_PD = 2'h1;
  // Values after reset
  localparam logic [7:0] CSRC_PLL_CONTROL_RST = 8'h01;
  localparam logic [7:0] CSRC_OSC_DIV_RATIO_RST = 8'h00;
  localparam logic [7:0] CSRC_DIST_ROUTING_RST = 8'h00;
  localparam logic [2:0] CSRC_OSC_RATIO_RST = 3'h2;
  // Serial frame lengths in bits
  localparam logic [4:0] CSRC_INSTR_BITS = 5'h10;
  localparam logic [4:0] CSRC_DATA_BITS = 5'h08;
  typedef enum logic [1:0] {
    CSRC_IDLE = 2'b00,
    CSRC_INSTR = 2'b01,
    CSRC_DATA = 2'b10,
    CSRC_DONE = 2'b11
  } csrc_state_t;
endpackage : csrc_pkg

//--- verilog/csrc_config.sv
`timescale 1ns/1ps
module csrc_config
  import csrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  input wire logic io_update,
  output logic pll_power_down,
  output logic pll_enable,
  output logic phase_detector_negative,
  output logic source_internal_osc,
  output logic divider_bypass,
  output logic [2:0] osc_divide_ratio,
  output logic internal_osc_power_on,
  output logic prescaler_from_external
);

  // Buffered registers written by the serial port
  logic [7:0] pll_control_reg;
  logic [7:0] osc_divider_ratio_reg;
  logic [7:0] distribution_input_routing_reg;
  // Active copies that steer the clock path
  logic [7:0] pll_control_act_reg;
  logic [7:0] osc_div_act_reg;
  logic [7:0] routing_act_reg;

  // Frame sequencer and read path state
  csrc_state_t state_reg;
  logic sclk_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] instr_reg;
  logic [7:0] data_reg;
  logic [7:0] rd_shift_reg;
  logic update_req_reg;
  logic out_bit_reg;
  logic oe_reg;

  // Decoded serial clock edges, shift previews and strobes
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] instr_next;
  logic [7:0] data_next;
  logic is_read;
  logic [12:0] instr_addr;
  logic wr_strobe;
  logic commit;

  // Maps a divider code onto a ratio of one to six
  function automatic logic [2:0] csrc_div_ratio(input logic [2:0] code);
    logic [2:0] ratio;
    ratio = 3'h1;
    if (code <= 3'h4) begin
      ratio = code + 3'h2; // [RQ8]
    end
    return ratio;
  endfunction : csrc_div_ratio

  // True when the PLL mode field selects normal operation
  function automatic logic csrc_is_normal(input logic [1:0] mode);
    return mode == CSRC_PLL_NORMAL;
  endfunction : csrc_is_normal

  // Read-back of the buffered registers; unmapped reads return zero
  function automatic logic [7:0] csrc_read(input logic [12:0] addr,
                                           input logic [7:0] pll_v,
                                           input logic [7:0] div_v,
                                           input logic [7:0] route_v);
    logic [7:0] val;
    val = 8'h00;
    if (addr == CSRC_PLL_CONTROL_ADDR) begin
      val = pll_v;
    end else if (addr == CSRC_OSC_DIV_RATIO_ADDR) begin
      val = div_v;
    end else if (addr == CSRC_DIST_ROUTING_ADDR) begin
      val = route_v;
    end
    return val;
  endfunction : csrc_read

  // Edges of the serial clock, sampled on the system clock
  assign sclk_rise = spi_sclk & ~sclk_prev_reg;
  assign sclk_fall = ~spi_sclk & sclk_prev_reg;
  assign instr_next = {instr_reg[14:0], spi_sdio_in};
  assign data_next = {data_reg[6:0], spi_sdio_in};
  assign is_read = instr_reg[15];
  assign instr_addr = instr_reg[12:0];
  // Last data bit of a write frame stages the byte
  assign wr_strobe = !spi_cs_n && state_reg == CSRC_DATA && sclk_rise && !is_read
      && bit_cnt_reg == CSRC_DATA_BITS - 5'h01;
  // Either the pin or the update register copies the staged set
  assign commit = io_update || update_req_reg;

  // Previous serial clock level; low matches the parked idle level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= spi_sclk;
    end
  end

  // Serial frame sequencer: 16-bit instruction then one data byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CSRC_IDLE;
      bit_cnt_reg <= 5'h00;
      instr_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else if (spi_cs_n) begin
      state_reg <= CSRC_IDLE;
      bit_cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        CSRC_IDLE: begin
          state_reg <= CSRC_INSTR;
          bit_cnt_reg <= 5'h00;
        end
        CSRC_INSTR: begin
          if (sclk_rise) begin
            instr_reg <= instr_next;
            if (bit_cnt_reg == CSRC_INSTR_BITS - 5'h01) begin
              state_reg <= CSRC_DATA;
              bit_cnt_reg <= 5'h00;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
          end
        end
        CSRC_DATA: begin
          if (sclk_rise) begin
            data_reg <= data_next;
            if (bit_cnt_reg == CSRC_DATA_BITS - 5'h01) begin
              state_reg <= CSRC_DONE;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
          end
        end
        CSRC_DONE: begin
          state_reg <= CSRC_DONE;
        end
        default: begin
          state_reg <= CSRC_IDLE;
        end
      endcase
    end
  end

  // Read byte captured as the instruction ends, shifted on each fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_shift_reg <= 8'h00;
    end else if (!spi_cs_n && state_reg == CSRC_INSTR) begin
      rd_shift_reg <= csrc_read(instr_next[12:0], pll_control_reg,
                                osc_divider_ratio_reg, distribution_input_routing_reg);
    end else if (!spi_cs_n && state_reg == CSRC_DATA && is_read && sclk_fall) begin
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // Read data driven MSB first, changing on falling serial clock edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_bit_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (spi_cs_n) begin
      oe_reg <= 1'b0;
      out_bit_reg <= 1'b0;
    end else if (state_reg == CSRC_DATA && is_read) begin
      if (sclk_fall) begin
        oe_reg <= 1'b1;
        out_bit_reg <= rd_shift_reg[7];
      end
    end else begin
      oe_reg <= 1'b0;
    end
  end

  // PLL control byte staged by a write frame; nothing moves until update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_control_reg <= CSRC_PLL_CONTROL_RST; // [RQ7]
    end else if (wr_strobe && instr_addr == CSRC_PLL_CONTROL_ADDR) begin
      pll_control_reg <= data_next;
    end
  end

  // Divider code byte staged by a write frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_divider_ratio_reg <= CSRC_OSC_DIV_RATIO_RST; // [RQ7]
    end else if (wr_strobe && instr_addr == CSRC_OSC_DIV_RATIO_ADDR) begin
      osc_divider_ratio_reg <= data_next;
    end
  end

  // Routing byte staged by a write frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      distribution_input_routing_reg <= CSRC_DIST_ROUTING_RST; // [RQ7]
    end else if (wr_strobe && instr_addr == CSRC_DIST_ROUTING_ADDR) begin
      distribution_input_routing_reg <= data_next;
    end
  end

  // Self-clearing update request from the update register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      update_req_reg <= 1'b0;
    end else begin
      update_req_reg <= wr_strobe && instr_addr == CSRC_UPDATE_ADDR
          && data_next[CSRC_UPDATE_BIT];
    end
  end

  // Active PLL control, copied as a whole so fields change together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_control_act_reg <= CSRC_PLL_CONTROL_RST; // [RQ7]
    end else if (commit) begin
      pll_control_act_reg <= pll_control_reg;
    end
  end

  // Active divider code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_div_act_reg <= CSRC_OSC_DIV_RATIO_RST; // [RQ7]
    end else if (commit) begin
      osc_div_act_reg <= osc_divider_ratio_reg;
    end
  end

  // Active routing byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      routing_act_reg <= CSRC_DIST_ROUTING_RST; // [RQ7]
    end else if (commit) begin
      routing_act_reg <= distribution_input_routing_reg;
    end
  end

  // PLL run state follows the active mode field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_power_down <= 1'b1;
      pll_enable <= 1'b0;
    end else begin
      // Only normal mode runs the loop; every other code keeps it off
      pll_enable <= csrc_is_normal(pll_control_act_reg[CSRC_PLL_MODE_LSB +: 2]); // [RQ2]
      pll_power_down <= !csrc_is_normal(pll_control_act_reg[CSRC_PLL_MODE_LSB +: 2]); // [RQ1]
    end
  end

  // Phase detector polarity from the active control byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_detector_negative <= 1'b0;
    end else begin
      phase_detector_negative <= pll_control_act_reg[CSRC_PD_POLARITY_BIT]; // [RQ6]
    end
  end

  // Source choice; the internal oscillator is powered only when chosen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      source_internal_osc <= 1'b0;
      internal_osc_power_on <= 1'b0;
    end else begin
      source_internal_osc <= routing_act_reg[CSRC_SOURCE_BIT]; // [RQ4] [RQ5]
      internal_osc_power_on <= routing_act_reg[CSRC_SOURCE_BIT]; // [RQ9]
    end
  end

  // Divider path: bypass bit and decoded ratio
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divider_bypass <= 1'b0;
      osc_divide_ratio <= CSRC_OSC_RATIO_RST;
    end else begin
      divider_bypass <= routing_act_reg[CSRC_BYPASS_BIT]; // [RQ3]
      osc_divide_ratio <= csrc_div_ratio(osc_div_act_reg[CSRC_DIV_CODE_LSB +: 3]); // [RQ8]
    end
  end

  // External oscillator reaches the feedback prescaler only with the loop on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescaler_from_external <= 1'b0;
    end else begin
      prescaler_from_external <= ~routing_act_reg[CSRC_SOURCE_BIT]
          & csrc_is_normal(pll_control_act_reg[CSRC_PLL_MODE_LSB +: 2]); // [RQ10]
    end
  end

  // Serial data pin driven straight from flops
  assign spi_sdio_out = out_bit_reg;
  assign spi_sdio_oe = oe_reg;

endmodule : csrc_config

//--- verification/csrc_host.sv
`timescale 1ns/1ps
module csrc_host (
  input wire logic clk,
  input wire logic spi_sdio_out,
  input wire logic spi_sdio_oe,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdio_in
);
  // Idle bus: deselected, serial clock parked low
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdio_in = 1'b0;
  end
  // One frame: 16 instruction bits then 8 data bits, MSB first
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    f = {ins, wd};
    @(negedge clk) spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdio_in = f[i];
      spi_sclk = 1'b0;
      repeat (3) @(negedge clk);
      if (i < 8)
        rd[i] = spi_sdio_oe ? spi_sdio_out : 1'bx;
      spi_sclk = 1'b1;
      repeat (2) @(negedge clk);
    end
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdio_in = ~spi_sdio_in; // Released line shows no stale bit
    repeat (2) @(negedge clk);
  endtask : xfer
endmodule : csrc_host

//--- verification/csrc_config_props.sv
`timescale 1ns/1ps
module csrc_config_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_oe,
  input wire logic io_update,
  input wire logic pll_power_down,
  input wire logic pll_enable,
  input wire logic phase_detector_negative,
  input wire logic source_internal_osc,
  input wire logic divider_bypass,
  input wire logic [2:0] osc_divide_ratio,
  input wire logic internal_osc_power_on,
  input wire logic prescaler_from_external
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Output relations
  a_mode_excl: assert property (pll_enable != pll_power_down)
    else $error("pll enable and power down disagree");
  a_osc_power: assert property (internal_osc_power_on == source_internal_osc)
    else $error("oscillator power does not follow source");
  a_presc_ext: assert property (prescaler_from_external == (pll_enable && !source_internal_osc))
    else $error("prescaler routing wrong");
  a_ratio_range: assert property (osc_divide_ratio inside {[3'h1:3'h6]})
    else $error("divide ratio out of range");
  a_reset_load: assert property ($fell(rst) |-> pll_power_down && osc_divide_ratio == 3'h2
    && !divider_bypass && !source_internal_osc) else $error("reset values wrong");
  a_oe_idle: assert property (spi_cs_n [*3] |-> !spi_sdio_oe)
    else $error("sdio driven while deselected");
  // An update comes from the pin two cycles before, or from any selected frame three cycles before
  a_pol_update: assert property ($changed(phase_detector_negative)
    |-> $past(io_update, 2) || $past(!spi_cs_n, 3)) else $error("polarity moved without update");
  a_route_update: assert property ($changed({divider_bypass, source_internal_osc,
    osc_divide_ratio, pll_enable}) |-> $past(io_update, 2) || $past(!spi_cs_n, 3))
    else $error("route moved early");
  // Main scenarios reached
  c_ext_lock: cover property (pll_enable && phase_detector_negative && prescaler_from_external);
  c_int_bypass: cover property (divider_bypass && source_internal_osc);
  c_read: cover property (spi_sdio_oe);
endmodule : csrc_config_props
bind csrc_config csrc_config_props u_csrc_config_props (.clk, .rst, .spi_cs_n, .spi_sdio_oe,
  .io_update, .pll_power_down, .pll_enable, .phase_detector_negative, .source_internal_osc,
  .divider_bypass, .osc_divide_ratio, .internal_osc_power_on, .prescaler_from_external);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csrc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io_update = 1'b0;
  logic spi_cs_n, spi_sclk, spi_sdio_in, spi_sdio_out, spi_sdio_oe;
  logic pll_power_down, pll_enable, phase_detector_negative, source_internal_osc;
  logic divider_bypass, internal_osc_power_on, prescaler_from_external;
  logic [2:0] osc_divide_ratio;
  logic [7:0] pv [8] = '{8'h01, 8'h80, 8'h00, 8'h02, 8'h03, 8'h81, 8'h00, 8'h01};
  logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h01, 8'h00, 8'h03, 8'h02};
  logic [9:0] want;
  logic [9:0] st;
  int mismatches = 0;
  int cmp_count = 0;
  // Observed outputs packed for comparison
  assign st = {pll_power_down, pll_enable, phase_detector_negative, source_internal_osc,
    divider_bypass, osc_divide_ratio, internal_osc_power_on, prescaler_from_external};
  // 10 MHz clock
  always #50 clk = ~clk;
  csrc_host u_csrc_host (.clk, .spi_cs_n, .spi_sclk, .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe);
  csrc_config u_csrc_config (.clk, .rst, .spi_cs_n, .spi_sclk, .spi_sdio_in, .spi_sdio_out,
    .spi_sdio_oe, .io_update, .pll_power_down, .pll_enable, .phase_detector_negative,
    .source_internal_osc, .divider_bypass, .osc_divide_ratio, .internal_osc_power_on,
    .prescaler_from_external);
  // Expected outputs from the three register values
  function automatic logic [9:0] expo(input logic [7:0] p, input logic [7:0] d,
      input logic [7:0] r);
    logic on;
    logic [2:0] q;
    on = (p[1:0] == 2'h0);
    q = (d[2:0] > 3'h4) ? 3'h1 : d[2:0] + 3'h2;
    return {!on, on, p[7], r[1], r[0], q, r[1], on & !r[1]};
  endfunction : expo
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_csrc_host.xfer({3'b000, a}, d, x);
  endtask : wr
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] x;
    u_csrc_host.xfer({3'b100, a}, 8'h00, x);
    chk({2'b00, x}, {2'b00, e});
  endtask : rdc
  task automatic upd;
    io_update = 1'b1;
    @(negedge clk) io_update = 1'b0;
    repeat (3) @(negedge clk);
  endtask : upd
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Main sequence: reset values, then each mode staged and committed
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    want = expo(8'h01, 8'h00, 8'h00);
    chk(st, want);
    rdc(CSRC_PLL_CONTROL_ADDR, 8'h01);
    rdc(CSRC_OSC_DIV_RATIO_ADDR, 8'h00);
    rdc(CSRC_DIST_ROUTING_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(CSRC_PLL_CONTROL_ADDR, pv[i]);
      wr(CSRC_OSC_DIV_RATIO_ADDR, 8'(i));
      wr(CSRC_DIST_ROUTING_ADDR, rv[i]);
      chk(st, want);
      upd();
      want = expo(pv[i], 8'(i), rv[i]);
      chk(st, want);
      rdc(CSRC_PLL_CONTROL_ADDR, pv[i]);
    end
    // Commit through the update register instead of the pin
    wr(CSRC_PLL_CONTROL_ADDR, 8'h80);
    wr(CSRC_DIST_ROUTING_ADDR, 8'h01);
    chk(st, want);
    wr(CSRC_UPDATE_ADDR, 8'h01);
    want = expo(8'h80, 8'h07, 8'h01);
    chk(st, want);
    wr(13'h0011, 8'h5A);
    rdc(13'h0011, 8'h00);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(st, expo(8'h01, 8'h00, 8'h00));
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial begin
    #2_000_000;
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
